// ==== rtl/charge_counter_consts.svh ====
`ifndef CHARGE_COUNTER_CONSTS_SVH
`define CHARGE_COUNTER_CONSTS_SVH

// Register offsets, one 16-bit word each
`define CT_OFF_ALERT_EN     8'h0d
`define CT_OFF_LOW_TH       8'h10
`define CT_OFF_HIGH_TH      8'h11
`define CT_OFF_DIVISOR      8'h12
`define CT_OFF_ACCUM        8'h13
`define CT_OFF_CONFIG       8'h14
`define CT_OFF_ALERT_FLAGS  8'h3a

// Field positions
`define CT_BIT_COUNT_EN     2
`define CT_BIT_LOW_ALERT    13
`define CT_BIT_HIGH_ALERT   12

// Reset values
`define CT_RST_DIVISOR      16'h0200
`define CT_RST_ACCUM        16'h0000
`define CT_RST_LOW_TH       16'h0000
`define CT_RST_HIGH_TH      16'hffff

// Accumulator and divisor limits
`define CT_ACC_MIN          16'h0000
`define CT_ACC_MAX          16'hffff
`define CT_DIV_MIN          16'h0001

// Serial port addresses; the device address is arbitrary
`define CT_DEV_ADDR         7'h2a
`define CT_ARA_ADDR         7'h0c

// Synchroniser reset levels: scl, sda idle high
`define CT_SYNC_RST         5'h18

`endif

// ==== rtl/charge_counter_pkg.sv ====
package charge_counter_pkg;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_RX,
    I2C_ACK,
    I2C_TX,
    I2C_RACK
  } i2c_state_e;

endpackage

// ==== rtl/bit_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // First stage feeds only the second stage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_q[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== rtl/tick_prescaler.sv ====
`timescale 1ns/100ps
`default_nettype none

module tick_prescaler #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             enable,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] divisor,
  input  wire logic             step_up,
  input  wire logic             step_down,
  output var  logic             overflow_q,
  output var  logic             underflow_q
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] top;
  logic             at_top;
  logic             at_bottom;

  // A zero divisor behaves as one, so every tick still steps
  assign top       = (divisor == '0) ? '0 : divisor - {{(WIDTH-1){1'b0}}, 1'b1};
  assign at_top    = (count_q >= top);
  assign at_bottom = (count_q == '0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (restart) begin
      count_q <= '0;
    end else if (enable && step_up) begin
      count_q <= at_top ? '0 : count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (enable && step_down) begin
      count_q <= at_bottom ? top : count_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow_q  <= 1'b0;
      underflow_q <= 1'b0;
    end else begin
      overflow_q  <= enable && !restart && step_up && at_top;
      underflow_q <= enable && !restart && !step_up && step_down && at_bottom;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/charge_tick_accumulator.sv ====
// Behaviour
// - Counter resets disabled; only host write enables
// - Counter enable is config register bit 2
// - Low alert enable at bit 13
// - High alert enable at bit 12
// - Accumulator is 16-bit register at 0x13
// - Lower threshold register at 0x10
// - Upper threshold register at 0x11
// - Divisor 1 to 65535, resets to 512
// - Prescaler overflow increments, underflow decrements accumulator
// - Tick sign from switch state and ramp
// - Accumulator saturates at 0 and 65535
// - Host reads return current accumulator value
// - Host writes accumulator; counting continues from it
// - Each limit alert individually maskable
// - Above upper threshold: alert line, high flag
// - Below lower threshold: alert line, low flag
`timescale 1ns/100ps
`default_nettype none
`include "charge_counter_consts.svh"

module charge_tick_accumulator
  import charge_counter_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `CT_DEV_ADDR
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe,
  output var  logic smbalert_o,
  output var  logic smbalert_oe,
  input  wire logic vtof_tick,
  input  wire logic vtof_switch_state,
  input  wire logic vtof_ramp_rising
);

  logic [4:0]  sync_bus;
  logic        scl_s;
  logic        sda_s;
  logic        tick_s;
  logic        switch_s;
  logic        ramp_s;
  logic        scl_p_q;
  logic        sda_p_q;
  logic        tick_p_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;

  i2c_state_e  state_q;
  logic [3:0]  bit_cnt_q;
  logic [2:0]  byte_idx_q;
  logic [7:0]  shift_q;
  logic [7:0]  cmd_q;
  logic [7:0]  wlo_q;
  logic [7:0]  tx_hi_q;
  logic        rw_q;
  logic        ack_ok_q;
  logic        ara_q;
  logic        ara_done_q;
  logic        wr_stb_q;
  logic [15:0] wr_data_q;
  logic [15:0] rd_word;

  logic        count_enable_q;
  logic        low_limit_alert_enable_q;
  logic        high_limit_alert_enable_q;
  logic [15:0] charge_low_threshold_q;
  logic [15:0] charge_high_threshold_q;
  logic [15:0] tick_divisor_q;
  logic [15:0] charge_accumulator_q;
  logic        low_limit_alert_flag_q;
  logic        high_limit_alert_flag_q;
  logic        alert_masked_q;

  logic        tick_edge;
  logic        step_up;
  logic        step_down;
  logic        acc_inc;
  logic        acc_dec;
  logic        low_hit;
  logic        high_hit;
  logic        new_event;
  logic        alert_pend;

  function automatic logic reg_hit(input logic [7:0] cmd, input logic [7:0] off);
    reg_hit = (cmd == off);
  endfunction

  // Pins and converter ticks enter through two flops each
  bit_sync #(
    .WIDTH   (5),
    .RST_VAL (`CT_SYNC_RST)
  ) u_sync (
    .clk      (core_clk),
    .rst      (sys_rst),
    .async_in ({scl_i, sda_i, vtof_tick, vtof_switch_state, vtof_ramp_rising}),
    .sync_out (sync_bus)
  );

  assign scl_s    = sync_bus[4];
  assign sda_s    = sync_bus[3];
  assign tick_s   = sync_bus[2];
  assign switch_s = sync_bus[1];
  assign ramp_s   = sync_bus[0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
      tick_p_q <= 1'b0;
    end else begin
      scl_p_q  <= scl_s;
      sda_p_q  <= sda_s;
      tick_p_q <= tick_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // One rising tick edge gives one signed step at most per cycle
  assign tick_edge = tick_s & ~tick_p_q;
  assign step_up   = tick_edge & (switch_s ~^ ramp_s);
  assign step_down = tick_edge & (switch_s ^ ramp_s);

  // Serial engine: SMBus word write and word read, low byte first
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= I2C_IDLE;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= 3'h0;
      shift_q    <= 8'h00;
      cmd_q      <= 8'h00;
      wlo_q      <= 8'h00;
      tx_hi_q    <= 8'h00;
      rw_q       <= 1'b0;
      ack_ok_q   <= 1'b0;
      ara_q      <= 1'b0;
      ara_done_q <= 1'b0;
      wr_stb_q   <= 1'b0;
      wr_data_q  <= 16'h0000;
    end else begin
      wr_stb_q   <= 1'b0;
      ara_done_q <= 1'b0;
      if (bus_start) begin
        state_q    <= I2C_RX;
        bit_cnt_q  <= 4'h0;
        byte_idx_q <= 3'h0;
      end else if (bus_stop) begin
        state_q <= I2C_IDLE;
      end else begin
        case (state_q)
          I2C_IDLE: begin
            bit_cnt_q <= 4'h0;
          end
          I2C_RX: begin
            if (scl_rise && bit_cnt_q != 4'h8) begin
              shift_q   <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              state_q   <= I2C_ACK;
              if (byte_idx_q != 3'h4) begin
                byte_idx_q <= byte_idx_q + 3'h1;
              end
              case (byte_idx_q)
                3'h0: begin
                  ara_q <= 1'b0;
                  if (shift_q[7:1] == DEV_ADDR) begin
                    rw_q <= shift_q[0];
                  end else if (shift_q[7:1] == `CT_ARA_ADDR && shift_q[0] && smbalert_oe) begin
                    rw_q  <= 1'b1;
                    ara_q <= 1'b1;
                  end else begin
                    state_q <= I2C_IDLE;
                  end
                end
                3'h1: cmd_q <= shift_q;
                3'h2: wlo_q <= shift_q;
                3'h3: begin
                  wr_data_q <= {shift_q, wlo_q};
                  wr_stb_q  <= 1'b1;
                end
                default: state_q <= I2C_IDLE;
              endcase
            end
          end
          I2C_ACK: begin
            if (scl_fall) begin
              if (rw_q && byte_idx_q == 3'h1) begin
                state_q <= I2C_TX;
                if (ara_q) begin
                  shift_q    <= {DEV_ADDR, 1'b0};
                  tx_hi_q    <= 8'h00;
                  ara_done_q <= 1'b1;
                end else begin
                  // Whole word captured at once so the two bytes never tear
                  shift_q <= rd_word[7:0];
                  tx_hi_q <= rd_word[15:8];
                end
              end else begin
                state_q <= I2C_RX;
              end
            end
          end
          I2C_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                bit_cnt_q <= 4'h0;
                state_q   <= I2C_RACK;
              end else begin
                shift_q   <= {shift_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          I2C_RACK: begin
            if (scl_rise) begin
              ack_ok_q <= ~sda_s;
            end else if (scl_fall) begin
              if (ack_ok_q) begin
                state_q <= I2C_TX;
                shift_q <= tx_hi_q;
                tx_hi_q <= 8'h00;
              end else begin
                state_q <= I2C_IDLE;
              end
            end
          end
          default: state_q <= I2C_IDLE;
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign sda_o  = 1'b0;
  assign sda_oe = (state_q == I2C_ACK) || (state_q == I2C_TX && !shift_q[7]);

  always_comb begin
    rd_word = 16'h0000;
    if (reg_hit(cmd_q, `CT_OFF_ALERT_EN)) begin
      rd_word[`CT_BIT_LOW_ALERT]  = low_limit_alert_enable_q;
      rd_word[`CT_BIT_HIGH_ALERT] = high_limit_alert_enable_q;
    end else if (reg_hit(cmd_q, `CT_OFF_LOW_TH)) begin
      rd_word = charge_low_threshold_q;
    end else if (reg_hit(cmd_q, `CT_OFF_HIGH_TH)) begin
      rd_word = charge_high_threshold_q;
    end else if (reg_hit(cmd_q, `CT_OFF_DIVISOR)) begin
      rd_word = tick_divisor_q;
    end else if (reg_hit(cmd_q, `CT_OFF_ACCUM)) begin
      rd_word = charge_accumulator_q;
    end else if (reg_hit(cmd_q, `CT_OFF_CONFIG)) begin
      rd_word[`CT_BIT_COUNT_EN] = count_enable_q;
    end else if (reg_hit(cmd_q, `CT_OFF_ALERT_FLAGS)) begin
      rd_word[`CT_BIT_LOW_ALERT]  = low_limit_alert_flag_q;
      rd_word[`CT_BIT_HIGH_ALERT] = high_limit_alert_flag_q;
    end
  end

  // No pin reaches the enable; it changes only by a host write
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_enable_q <= 1'b0;
    end else if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_CONFIG)) begin
      count_enable_q <= wr_data_q[`CT_BIT_COUNT_EN];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_limit_alert_enable_q  <= 1'b0;
      high_limit_alert_enable_q <= 1'b0;
    end else if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_ALERT_EN)) begin
      low_limit_alert_enable_q  <= wr_data_q[`CT_BIT_LOW_ALERT];
      high_limit_alert_enable_q <= wr_data_q[`CT_BIT_HIGH_ALERT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_low_threshold_q  <= `CT_RST_LOW_TH;
      charge_high_threshold_q <= `CT_RST_HIGH_TH;
    end else begin
      if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_LOW_TH)) begin
        charge_low_threshold_q <= wr_data_q;
      end
      if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_HIGH_TH)) begin
        charge_high_threshold_q <= wr_data_q;
      end
    end
  end

  // A zero write is stored as one to keep the divisor in range
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_divisor_q <= `CT_RST_DIVISOR;
    end else if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_DIVISOR)) begin
      tick_divisor_q <= (wr_data_q == 16'h0000) ? `CT_DIV_MIN : wr_data_q;
    end
  end

  tick_prescaler #(
    .WIDTH (16)
  ) u_prescaler (
    .clk         (core_clk),
    .rst         (sys_rst),
    .enable      (count_enable_q),
    .restart     (wr_stb_q && reg_hit(cmd_q, `CT_OFF_DIVISOR)),
    .divisor     (tick_divisor_q),
    .step_up     (step_up),
    .step_down   (step_down),
    .overflow_q  (acc_inc),
    .underflow_q (acc_dec)
  );

  // Host write wins over a step in the same cycle; that step is dropped
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      charge_accumulator_q <= `CT_RST_ACCUM;
    end else if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_ACCUM)) begin
      charge_accumulator_q <= wr_data_q;
    end else if (acc_inc && charge_accumulator_q != `CT_ACC_MAX) begin
      charge_accumulator_q <= charge_accumulator_q + 16'h0001;
    end else if (acc_dec && charge_accumulator_q != `CT_ACC_MIN) begin
      charge_accumulator_q <= charge_accumulator_q - 16'h0001;
    end
  end

  assign high_hit = high_limit_alert_enable_q && (charge_accumulator_q > charge_high_threshold_q);
  assign low_hit  = low_limit_alert_enable_q && (charge_accumulator_q < charge_low_threshold_q);

  // Set beats a write-one clear in the same cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_limit_alert_flag_q <= 1'b0;
      low_limit_alert_flag_q  <= 1'b0;
    end else begin
      if (high_hit) begin
        high_limit_alert_flag_q <= 1'b1;
      end else if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_ALERT_FLAGS)
                   && wr_data_q[`CT_BIT_HIGH_ALERT]) begin
        high_limit_alert_flag_q <= 1'b0;
      end
      if (low_hit) begin
        low_limit_alert_flag_q <= 1'b1;
      end else if (wr_stb_q && reg_hit(cmd_q, `CT_OFF_ALERT_FLAGS)
                   && wr_data_q[`CT_BIT_LOW_ALERT]) begin
        low_limit_alert_flag_q <= 1'b0;
      end
    end
  end

  assign alert_pend = (high_limit_alert_flag_q && high_limit_alert_enable_q)
                    || (low_limit_alert_flag_q && low_limit_alert_enable_q);
  assign new_event  = (high_hit && !high_limit_alert_flag_q)
                    || (low_hit && !low_limit_alert_flag_q);

  // Answering the alert response address quiets the line until a fresh event
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_masked_q <= 1'b0;
    end else if (new_event) begin
      alert_masked_q <= 1'b0;
    end else if (ara_done_q) begin
      alert_masked_q <= 1'b1;
    end else if (!alert_pend) begin
      alert_masked_q <= 1'b0;
    end
  end

  assign smbalert_o  = 1'b0;
  assign smbalert_oe = alert_pend && !alert_masked_q;

endmodule

`default_nettype wire

// ==== tb/smbus_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic core_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic host_sda_oe,
  output var  logic nack_seen
);
  // Phases well above the 4-cycle detection floor of the device
  localparam int HALF = 6;
  initial begin
    scl = 1'b1;
    host_sda_oe = 1'b0;
    nack_seen = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // One extra low cycle so SDA never moves in the sample where SCL falls
  task automatic clk_bit(output logic b);
    hold(HALF);
    scl = 1'b1;
    hold(HALF / 2);
    b = sda_line;
    hold(HALF - HALF / 2);
    scl = 1'b0;
    hold(1);
  endtask
  task automatic start();
    host_sda_oe = 1'b0;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    host_sda_oe = 1'b1;
    hold(HALF);
    scl = 1'b0;
    hold(1);
  endtask
  task automatic stop();
    host_sda_oe = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    host_sda_oe = 1'b0;
    hold(HALF);
  endtask
  task automatic send(input logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      host_sda_oe = !d[i];
      clk_bit(b);
    end
    host_sda_oe = 1'b0;
    clk_bit(b);
    if (b !== 1'b0) nack_seen = 1'b1;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic b;
    host_sda_oe = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b);
      d[i] = b;
    end
    host_sda_oe = !last;
    clk_bit(b);
    host_sda_oe = 1'b0;
  endtask
  // Words go low byte first; a host write may land at any time
  task automatic wr_word(input logic [7:0] cmd, input logic [15:0] d);
    start();
    send({ADDR, 1'b0});
    send(cmd);
    send(d[7:0]);
    send(d[15:8]);
    stop();
  endtask
  task automatic rd_word(input logic [7:0] cmd, output logic [15:0] d);
    start();
    send({ADDR, 1'b0});
    send(cmd);
    start();
    send({ADDR, 1'b1});
    recv(1'b0, d[7:0]);
    recv(1'b1, d[15:8]);
    stop();
  endtask
  // Alert response address is fixed by the bus standard; one byte, then NACK
  task automatic ara_read(output logic [7:0] d);
    start();
    send({7'h0c, 1'b1});
    recv(1'b1, d);
    stop();
  endtask
endmodule
`default_nettype wire

// ==== tb/charge_tick_accumulator_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module charge_tick_accumulator_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic smbalert_o,
  input wire logic smbalert_oe,
  input wire logic vtof_tick,
  input wire logic vtof_switch_state,
  input wire logic vtof_ramp_rising
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_RST_NO_DRIVE: assert property ($fell(sys_rst) |-> (!sda_oe) [*3])
    else $error("SDA driven right after reset");
  AST_RST_NO_ALERT: assert property ($fell(sys_rst) |-> !smbalert_oe ##1 !smbalert_oe)
    else $error("Alert asserted right after reset");
  AST_SDA_PULL_LEVEL: assert property (sda_o == 1'b0)
    else $error("SDA output level not low");
  AST_ALERT_PULL_LEVEL: assert property (smbalert_o == 1'b0)
    else $error("Alert output level not low");
  // Data may only move while SCL is low, well after its fall
  AST_OE_MOVES_SCL_LOW: assert property (
    $changed(sda_oe) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2))
    else $error("SDA drive changed near SCL high");
  AST_OE_HELD_ON_RISE: assert property ($rose(scl_i) |-> ##1 $stable(sda_oe) [*4])
    else $error("SDA drive changed after SCL rise");
  AST_OE_STILL_SCL_HIGH: assert property (scl_i [*5] |-> $stable(sda_oe))
    else $error("SDA drive changed during SCL high");
  // Without ticks or bus activity nothing can move the alert
  AST_ALERT_QUIET: assert property (
    ($stable(scl_i) && $stable(vtof_tick)) [*8] |-> $stable(smbalert_oe))
    else $error("Alert changed without cause");
endmodule
bind charge_tick_accumulator charge_tick_accumulator_asserts i_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe),
  .vtof_tick(vtof_tick), .vtof_switch_state(vtof_switch_state),
  .vtof_ramp_rising(vtof_ramp_rising)
);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "charge_counter_consts.svh"
module tb_top;
  logic core_clk;
  logic sys_rst;
  logic scl;
  logic host_sda_oe;
  logic nack_seen;
  logic sda_line;
  logic sda_o;
  logic sda_oe;
  logic smbalert_o;
  logic smbalert_oe;
  logic vtof_tick;
  logic vtof_switch_state;
  logic vtof_ramp_rising;
  int   err_total;
  int   n_tests;
  logic [7:0] ara_d;
  logic [7:0]  offs [8] = '{`CT_OFF_ALERT_EN, `CT_OFF_LOW_TH, `CT_OFF_HIGH_TH, `CT_OFF_DIVISOR,
                            `CT_OFF_ACCUM, `CT_OFF_CONFIG, `CT_OFF_ALERT_FLAGS, 8'h20};
  logic [15:0] rst_v [8] = '{16'h0000, `CT_RST_LOW_TH, `CT_RST_HIGH_TH, 16'h0200,
                            16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0]  w_off [9] = '{`CT_OFF_ALERT_EN, `CT_OFF_ALERT_EN, `CT_OFF_LOW_TH, `CT_OFF_HIGH_TH,
                            `CT_OFF_DIVISOR, `CT_OFF_DIVISOR, 8'h20, `CT_OFF_DIVISOR,
                            `CT_OFF_CONFIG};
  logic [15:0] w_val [9] = '{16'hffff, 16'h0000, 16'h1234, 16'habcd, 16'hffff, 16'h0000,
                            16'h5555, 16'h0002, 16'h0004};
  logic [15:0] w_exp [9] = '{16'h3000, 16'h0000, 16'h1234, 16'habcd, 16'hffff, 16'h0001,
                            16'h0000, 16'h0002, 16'h0004};
  // Open-drain SDA with pull-up
  assign sda_line = !(host_sda_oe || sda_oe);
  charge_tick_accumulator i_charge_tick_accumulator (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe),
    .vtof_tick(vtof_tick), .vtof_switch_state(vtof_switch_state),
    .vtof_ramp_rising(vtof_ramp_rising)
  );
  smbus_host_model i_smbus_host_model (
    .core_clk(core_clk), .sda_line(sda_line), .scl(scl), .host_sda_oe(host_sda_oe),
    .nack_seen(nack_seen)
  );
  always #20 core_clk = ~core_clk;
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    i_smbus_host_model.rd_word(cmd, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    i_smbus_host_model.wr_word(cmd, d);
  endtask
  // Each tick is a 3-cycle pulse so the synchroniser sees every edge
  task automatic ticks(input int n, input logic sw, input logic rp);
    vtof_switch_state = sw;
    vtof_ramp_rising = rp;
    repeat (n) begin
      @(negedge core_clk);
      vtof_tick = 1'b1;
      repeat (3) @(negedge core_clk);
      vtof_tick = 1'b0;
      repeat (3) @(negedge core_clk);
    end
    repeat (10) @(negedge core_clk);
  endtask
  task automatic wait_alert(input logic exp);
    for (int i = 0; i < 40 && smbalert_oe !== exp; i++) @(negedge core_clk);
    chk({15'h0, smbalert_oe}, {15'h0, exp});
    if (smbalert_oe !== exp) report_and_stop();
  endtask
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    vtof_tick = 1'b0;
    vtof_switch_state = 1'b0;
    vtof_ramp_rising = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 8; i++) rd_chk(offs[i], rst_v[i]);
    ticks(4, 1'b1, 1'b1);
    rd_chk(`CT_OFF_ACCUM, 16'h0000);
    $display("Test reset done");
    for (int i = 0; i < 9; i++) begin
      wr(w_off[i], w_val[i]);
      rd_chk(w_off[i], w_exp[i]);
    end
    $display("Test registers done");
    ticks(6, 1'b1, 1'b1);
    rd_chk(`CT_OFF_ACCUM, 16'h0003);
    wr(`CT_OFF_DIVISOR, 16'h0001);
    wr(`CT_OFF_ACCUM, 16'h0005);
    ticks(3, 1'b1, 1'b0);
    rd_chk(`CT_OFF_ACCUM, 16'h0002);
    ticks(2, 1'b0, 1'b0);
    rd_chk(`CT_OFF_ACCUM, 16'h0004);
    $display("Test counting done");
    wr(`CT_OFF_ACCUM, 16'hffff);
    ticks(2, 1'b1, 1'b1);
    rd_chk(`CT_OFF_ACCUM, 16'hffff);
    wr(`CT_OFF_ACCUM, 16'h0000);
    ticks(2, 1'b1, 1'b0);
    rd_chk(`CT_OFF_ACCUM, 16'h0000);
    $display("Test saturation done");
    wr(`CT_OFF_HIGH_TH, 16'h0005);
    wr(`CT_OFF_ACCUM, 16'h0006);
    wait_alert(1'b0);
    wr(`CT_OFF_ALERT_EN, 16'h1000);
    wait_alert(1'b1);
    rd_chk(`CT_OFF_ALERT_FLAGS, 16'h1000);
    // Alert response read names this device and quiets the line
    i_smbus_host_model.ara_read(ara_d);
    chk({8'h00, ara_d}, {8'h00, `CT_DEV_ADDR, 1'b0});
    wait_alert(1'b0);
    wr(`CT_OFF_LOW_TH, 16'h0010);
    wr(`CT_OFF_ALERT_EN, 16'h2000);
    wr(`CT_OFF_ALERT_FLAGS, 16'h1000);
    wait_alert(1'b1);
    rd_chk(`CT_OFF_ALERT_FLAGS, 16'h2000);
    wr(`CT_OFF_ALERT_EN, 16'h0000);
    wait_alert(1'b0);
    $display("Test alerts done");
    chk({15'h0, nack_seen}, 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
